// ===== hw/signal_glitch_filter.sv
// Glitch filter: output follows input once it has held for a set time
`timescale 1ns/1ps
module signal_glitch_filter #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] delay,
   input  wire logic       din,
   output logic            dout
);
   logic [7:0] cnt;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         dout <= RESET_VAL;
         cnt  <= 8'h00;
      end else if (din == dout) begin
         cnt <= 8'h00;
      end else if (8'(cnt + 8'h01) >= delay) begin
         dout <= din;
         cnt  <= 8'h00;
      end else begin
         cnt <= 8'(cnt + 8'h01);
      end
   end
endmodule

// ===== hw/smbus_ctl_pkg.sv
// Constants shared by the SMBus port control block
package smbus_ctl_pkg;
   localparam int unsigned REG_ADDR_W      = 12;
   localparam int unsigned REG_DATA_W      = 32;
   // Register offsets
   localparam logic [11:0] CTRL_OFFSET     = 12'h348;
   localparam logic [11:0] EEPROM_OFFSET   = 12'h34C;
   localparam logic [11:0] STATUS_OFFSET   = 12'h360;
   // Control register fields
   localparam int unsigned DIV_LSB         = 0;
   localparam int unsigned IGN_BIT         = 16;
   localparam int unsigned SKIP_BIT        = 17;
   localparam int unsigned SFILT_LSB       = 18;
   localparam int unsigned MFILT_LSB       = 20;
   localparam int unsigned TDIS_BIT        = 22;
   // EEPROM access register fields
   localparam int unsigned ADDR_LSB        = 0;
   localparam int unsigned DATA_LSB        = 16;
   localparam int unsigned BUSY_BIT        = 24;
   localparam int unsigned DONE_BIT        = 25;
   localparam int unsigned OP_BIT          = 26;
   // Status register fields, all write-one-to-clear
   localparam int unsigned LOST_BIT        = 0;
   localparam int unsigned NACK_BIT        = 1;
   localparam int unsigned MTO_BIT         = 2;
   localparam int unsigned STO_BIT         = 3;
   localparam int unsigned CSUM_BIT        = 4;
   // Values after reset, and the EEPROM device address
   localparam logic [15:0] DIV_SLOW        = 16'h0139;
   localparam logic [15:0] DIV_FAST        = 16'h0531;
   localparam logic [6:0]  EEPROM_DEV_ADDR = 7'h50;
   localparam logic [6:0]  FILT_RESET      = 7'h33;
   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned PRESCALE_UNIT_NS = 32;
   localparam int unsigned FILT_NORMAL_NS  = 1000;
   localparam int unsigned FILT_FAST_NS    = 100;
   localparam logic [7:0]  FILT_NORMAL_CYC =
      8'((FILT_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0]  FILT_FAST_CYC   =
      8'((FILT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned TIMEOUT_NS      = 25000000;
   localparam logic [4:0]  ARB_MAX_LOSSES  = 5'h10;
   localparam logic [3:0]  ACK_SLOT        = 4'h8;

   typedef enum logic [1:0] {
      FILT_NORMAL   = 2'b00,
      FILT_FAST     = 2'b01,
      FILT_OFF      = 2'b10,
      FILT_RESERVED = 2'b11
   } filt_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_START   = 3'b001,
      ST_BIT     = 3'b010,
      ST_RESTART = 3'b011,
      ST_STOP    = 3'b100
   } eng_state_e;
endpackage

// ===== hw/smbus_port_control.sv
// SMBus master and slave port control with EEPROM access engine
`timescale 1ns/1ps
module smbus_port_control #(
   parameter int unsigned TIMEOUT_CYCLES =
      smbus_ctl_pkg::TIMEOUT_NS / smbus_ctl_pkg::CLK_PERIOD_NS
) (
   input  wire logic                                ref_clk,
   input  wire logic                                reset_n,
   input  wire logic                                fast_mode_strap,
   input  wire logic [smbus_ctl_pkg::REG_ADDR_W-1:0] reg_addr,
   input  wire logic [smbus_ctl_pkg::REG_DATA_W-1:0] reg_wdata,
   input  wire logic                                reg_write,
   input  wire logic                                reg_read,
   output logic      [smbus_ctl_pkg::REG_DATA_W-1:0] reg_rdata,
   input  wire logic                                master_scl_in,
   output logic                                     master_scl_out,
   output logic                                     master_scl_oe,
   input  wire logic                                master_sda_in,
   output logic                                     master_sda_out,
   output logic                                     master_sda_oe,
   input  wire logic                                slave_scl_in,
   input  wire logic                                slave_sda_in,
   output logic                                     slave_sda_out,
   output logic                                     slave_sda_oe,
   input  wire logic                                slave_sda_drive_low,
   output logic                                     slave_scl_filt,
   output logic                                     slave_sda_filt,
   output logic                                     slave_timeout,
   input  wire logic                                init_checksum_fail,
   output logic                                     init_checksum_error
);
   import smbus_ctl_pkg::*;

   localparam int unsigned TO_W = $clog2(TIMEOUT_CYCLES + 1);

   logic [15:0] div;
   logic        ign;
   logic        skip;
   logic [1:0]  sfilt;
   logic [1:0]  mfilt;
   logic        tdis;
   logic [15:0] ee_addr;
   logic [7:0]  ee_data;
   logic        ee_op;
   logic [7:0]  rx_data;
   logic        busy;
   logic        done;
   logic        lost_err;
   logic        nack_err;
   logic        mto_err;
   logic        sto_err;
   logic        csum_err;
   logic        wr_ctrl;
   logic        wr_ee;
   logic        wr_stat;
   logic        start;
   logic        ht;
   logic [20:0] acc;
   logic [20:0] half_ns;
   logic [20:0] next_acc;
   logic        stopped;
   eng_state_e  state;
   logic [2:0]  idx;
   logic [3:0]  bitcnt;
   logic [7:0]  shreg;
   logic        scl_lo;
   logic        sda_lo;
   logic [4:0]  losses;
   logic        arb_lost;
   logic        arb_abort;
   logic        nack_evt;
   logic        mto_hit;
   logic        sto_hit;
   logic [TO_W-1:0] mto_cnt;
   logic [TO_W-1:0] sto_cnt;
   logic [6:0]  filt_in;
   logic [6:0]  filt_out;
   logic        m_scl_f;
   logic        m_sda_f;

   assign wr_ctrl = reg_write && (reg_addr == CTRL_OFFSET);
   assign wr_ee   = reg_write && (reg_addr == EEPROM_OFFSET);
   assign wr_stat = reg_write && (reg_addr == STATUS_OFFSET);
   assign start   = wr_ee && !busy;

   function automatic logic [7:0] filt_delay(input logic [1:0] mode);
      case (mode)
         FILT_FAST: filt_delay = FILT_FAST_CYC;
         FILT_OFF:  filt_delay = 8'h00;
         // Reserved code behaves as the normal setting
         default:   filt_delay = FILT_NORMAL_CYC;
      endcase
   endfunction

   function automatic logic [7:0] tx_byte(input logic [2:0]  i,
                                          input logic [15:0] a,
                                          input logic [7:0]  d,
                                          input logic        rd);
      case (i)
         3'h0:    tx_byte = {EEPROM_DEV_ADDR, 1'b0};
         3'h1:    tx_byte = a[15:8];
         3'h2:    tx_byte = a[7:0];
         3'h3:    tx_byte = rd ? {EEPROM_DEV_ADDR, 1'b1} : d;
         default: tx_byte = 8'hFF;
      endcase
   endfunction

   // Control register; only the divider comes up from the boot strap
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div   <= fast_mode_strap ? DIV_FAST : DIV_SLOW;
         ign   <= 1'b0;
         skip  <= 1'b0;
         sfilt <= FILT_NORMAL;
         mfilt <= FILT_NORMAL;
         tdis  <= 1'b0;
      end else if (wr_ctrl) begin
         div   <= reg_wdata[DIV_LSB +: 16];
         ign   <= reg_wdata[IGN_BIT];
         skip  <= reg_wdata[SKIP_BIT];
         sfilt <= reg_wdata[SFILT_LSB +: 2];
         mfilt <= reg_wdata[MFILT_LSB +: 2];
         tdis  <= reg_wdata[TDIS_BIT];
      end
   end

   // Address and op may change while busy; the data byte is held
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ee_addr <= 16'h0000;
         ee_data <= 8'h00;
         ee_op   <= 1'b0;
      end else if (wr_ee) begin
         ee_addr <= reg_wdata[ADDR_LSB +: 16];
         ee_op   <= reg_wdata[OP_BIT];
         if (!busy) begin
            ee_data <= reg_wdata[DATA_LSB +: 8];
         end
      end
   end

   // Half-period ticks; fractional accumulation keeps the average exact
   assign stopped = (div <= 16'h0001);
   assign half_ns = 21'(div) * 21'(PRESCALE_UNIT_NS / 2);
   assign next_acc = 21'(acc + 21'(CLK_PERIOD_NS));

   // A new divider restarts the phase; a leftover sum would burst ticks
   always_ff @(posedge ref_clk) begin
      if (!reset_n || stopped ||
          (wr_ctrl && reg_wdata[DIV_LSB +: 16] != div)) begin
         acc <= 21'h000000;
         ht  <= 1'b0;
      end else if (next_acc >= half_ns) begin
         acc <= 21'(next_acc - half_ns);
         ht  <= 1'b1;
      end else begin
         acc <= next_acc;
         ht  <= 1'b0;
      end
   end

   // Filter channels: 0..3 master pins and drives, 4..6 slave
   assign filt_in = {slave_sda_drive_low, slave_sda_in, slave_scl_in,
                     sda_lo, scl_lo, master_sda_in, master_scl_in};

   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_filt
         signal_glitch_filter #(
            .RESET_VAL (FILT_RESET[g])
         ) u_filt (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .delay   (filt_delay(g < 4 ? mfilt : sfilt)),
            .din     (filt_in[g]),
            .dout    (filt_out[g])
         );
      end
   endgenerate

   assign m_scl_f        = filt_out[0];
   assign m_sda_f        = filt_out[1];
   assign master_scl_oe  = filt_out[2];
   assign master_sda_oe  = filt_out[3];
   assign master_scl_out = 1'b0;
   assign master_sda_out = 1'b0;
   assign slave_scl_filt = filt_out[4];
   assign slave_sda_filt = filt_out[5];
   assign slave_sda_oe   = filt_out[6];
   assign slave_sda_out  = 1'b0;

   // Clock held low too long on either port
   assign mto_hit = !tdis && !m_scl_f &&
                    (mto_cnt == TO_W'(TIMEOUT_CYCLES - 1));
   assign sto_hit = !tdis && !slave_scl_filt &&
                    (sto_cnt == TO_W'(TIMEOUT_CYCLES - 1));

   always_ff @(posedge ref_clk) begin
      if (!reset_n || tdis || m_scl_f || mto_hit) begin
         mto_cnt <= '0;
      end else begin
         mto_cnt <= TO_W'(mto_cnt + 1'b1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || tdis || slave_scl_filt || sto_hit) begin
         sto_cnt <= '0;
      end else begin
         sto_cnt <= TO_W'(sto_cnt + 1'b1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         slave_timeout <= 1'b0;
      end else begin
         slave_timeout <= sto_hit;
      end
   end

   // Arbitration: we released the line but someone pulls it low
   assign arb_lost  = ht && (state == ST_BIT) && !scl_lo &&
                      (bitcnt != ACK_SLOT) && (idx != 3'h4) &&
                      shreg[7] && !m_sda_f && !ign;
   assign arb_abort = arb_lost && (losses == 5'(ARB_MAX_LOSSES - 1));
   assign nack_evt  = ht && (state == ST_BIT) && !scl_lo &&
                      (bitcnt == ACK_SLOT) && (idx != 3'h4) && m_sda_f;

   // Transfer engine: bytes 0..4 are device, addr hi, addr lo,
   // data or device+read, read byte. Data moves on the same tick that pulls clock low.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state   <= ST_IDLE;
         idx     <= 3'h0;
         bitcnt  <= 4'h0;
         shreg   <= 8'hFF;
         scl_lo  <= 1'b0;
         sda_lo  <= 1'b0;
         losses  <= 5'h00;
         busy    <= 1'b0;
         done    <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         if (wr_ee && reg_wdata[DONE_BIT]) begin
            done <= 1'b0;
         end
         if (start) begin
            busy   <= 1'b1;
            losses <= 5'h00;
         end
         if (busy && mto_hit) begin
            state  <= ST_IDLE;
            scl_lo <= 1'b0;
            sda_lo <= 1'b0;
            busy   <= 1'b0;
            done   <= 1'b1;
         end else if (arb_lost) begin
            scl_lo <= 1'b0;
            sda_lo <= 1'b0;
            state  <= ST_IDLE;
            losses <= 5'(losses + 5'h01);
            if (arb_abort) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end else if (ht) begin
            case (state)
               ST_IDLE: begin
                  // Retries wait for a free bus after a loss
                  if (busy && m_scl_f && m_sda_f) begin
                     sda_lo <= 1'b1;
                     idx    <= 3'h0;
                     state  <= ST_START;
                  end
               end
               ST_START: begin
                  scl_lo <= 1'b1;
                  shreg  <= tx_byte(idx, ee_addr, ee_data, ee_op);
                  sda_lo <= ~tx_byte(idx, ee_addr, ee_data, ee_op)[7];
                  bitcnt <= 4'h0;
                  state  <= ST_BIT;
               end
               ST_BIT: begin
                  if (scl_lo) begin
                     scl_lo <= 1'b0;
                  end else if (bitcnt != ACK_SLOT) begin
                     shreg  <= {shreg[6:0], m_sda_f};
                     bitcnt <= 4'(bitcnt + 4'h1);
                     scl_lo <= 1'b1;
                     sda_lo <= (bitcnt == 4'h7) ? 1'b0 : ~shreg[6];
                  end else begin
                     scl_lo <= 1'b1;
                     if (nack_evt || idx == 3'h4 ||
                         (idx == 3'h3 && !ee_op)) begin
                        sda_lo <= 1'b1;
                        state  <= ST_STOP;
                        if (idx == 3'h4) begin
                           rx_data <= shreg;
                        end
                     end else if (idx == 3'h2 && ee_op) begin
                        sda_lo <= 1'b0;
                        state  <= ST_RESTART;
                     end else begin
                        idx    <= 3'(idx + 3'h1);
                        shreg  <= tx_byte(3'(idx + 3'h1), ee_addr,
                                          ee_data, ee_op);
                        sda_lo <= ~tx_byte(3'(idx + 3'h1), ee_addr,
                                           ee_data, ee_op)[7];
                        bitcnt <= 4'h0;
                     end
                  end
               end
               ST_RESTART: begin
                  if (scl_lo) begin
                     scl_lo <= 1'b0;
                  end else begin
                     sda_lo <= 1'b1;
                     idx    <= 3'h3;
                     state  <= ST_START;
                  end
               end
               ST_STOP: begin
                  if (scl_lo) begin
                     scl_lo <= 1'b0;
                  end else begin
                     sda_lo <= 1'b0;
                     state  <= ST_IDLE;
                     busy   <= 1'b0;
                     done   <= 1'b1;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Status flags: a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lost_err <= 1'b0;
         nack_err <= 1'b0;
         mto_err  <= 1'b0;
         sto_err  <= 1'b0;
         csum_err <= 1'b0;
      end else begin
         lost_err <= arb_abort ||
                     (lost_err && !(wr_stat && reg_wdata[LOST_BIT]));
         nack_err <= nack_evt ||
                     (nack_err && !(wr_stat && reg_wdata[NACK_BIT]));
         mto_err  <= mto_hit ||
                     (mto_err && !(wr_stat && reg_wdata[MTO_BIT]));
         sto_err  <= sto_hit ||
                     (sto_err && !(wr_stat && reg_wdata[STO_BIT]));
         csum_err <= (init_checksum_fail && !skip) ||
                     (csum_err && !(wr_stat && reg_wdata[CSUM_BIT]));
      end
   end

   assign init_checksum_error = csum_err;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            CTRL_OFFSET:   reg_rdata <= {9'h000, tdis, mfilt, sfilt, skip,
                                         ign, div};
            EEPROM_OFFSET: reg_rdata <= {5'h00, ee_op, done, busy,
                                         ee_op ? rx_data : ee_data,
                                         ee_addr};
            STATUS_OFFSET: reg_rdata <= {27'h0000000, csum_err, sto_err,
                                         mto_err, nack_err, lost_err};
            default:       reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   property p_stop;
      @(posedge ref_clk) disable iff (!reset_n)
      stopped |=> !ht;
   endproperty
   a_stop: assert property (p_stop)
      else $error("prescaler ticked while stopped");

   property p_boot;
      @(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |->
         div == ($past(fast_mode_strap) ? DIV_FAST : DIV_SLOW);
   endproperty
   a_boot: assert property (p_boot)
      else $error("divider boot value wrong");

   property p_half;
      @(posedge ref_clk) disable iff (!reset_n)
      ht && !stopped |=> !ht [*3];
   endproperty
   a_half: assert property (p_half)
      else $error("half period too short");

   property p_ign;
      @(posedge ref_clk) disable iff (!reset_n)
      ign && $past(ign) && $past(busy) && busy |->
         losses == $past(losses);
   endproperty
   a_ign: assert property (p_ign)
      else $error("loss counted while ignoring arbitration");

   property p_skip;
      @(posedge ref_clk) disable iff (!reset_n)
      skip && init_checksum_fail && !csum_err |=> !csum_err;
   endproperty
   a_skip: assert property (p_skip)
      else $error("checksum error raised while skipped");

   property p_sfilt;
      @(posedge ref_clk) disable iff (!reset_n)
      sfilt == FILT_OFF && $past(sfilt == FILT_OFF) |->
         slave_scl_filt == $past(slave_scl_in);
   endproperty
   a_sfilt: assert property (p_sfilt)
      else $error("slave filter off but delayed");

   property p_tdis;
      @(posedge ref_clk) disable iff (!reset_n)
      tdis && $past(tdis) |-> !mto_err || $past(mto_err);
   endproperty
   a_tdis: assert property (p_tdis)
      else $error("timeout flagged while disabled");

   property p_start;
      @(posedge ref_clk) disable iff (!reset_n)
      wr_ee && !busy |=> busy;
   endproperty
   a_start: assert property (p_start)
      else $error("data write did not start access");

   property p_done;
      @(posedge ref_clk) disable iff (!reset_n)
      $fell(busy) |-> done;
   endproperty
   a_done: assert property (p_done)
      else $error("done not set at end of access");

   property p_abort;
      @(posedge ref_clk) disable iff (!reset_n)
      arb_abort |=> !busy && lost_err && losses == ARB_MAX_LOSSES;
   endproperty
   a_abort: assert property (p_abort)
      else $error("no abort after sixteen losses");
endmodule

// ===== tb/eeprom_model.sv
// Behavioural serial EEPROM on the master bus port
`timescale 1ns/1ps
module eeprom_model #(
   parameter logic [7:0] RD_BYTE = 8'hC3
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      drive_low
);
   logic [7:0] got [0:15];
   logic [7:0] sh;
   int         n = 0;
   int         bits = 0;
   int         edges = 0;
   logic       tx = 1'b0;
   realtime    last = 0.0;
   realtime    per = 0.0;
   initial drive_low = 1'b0;
   // Looked at 1 ns late: a data change on the clock fall is no condition
   always @(sda) begin
      #1;
      if (scl === 1'b1) begin
         bits = 0;
         tx = 1'b0;
         drive_low = 1'b0;
      end
   end
   always @(posedge scl) begin
      edges++;
      if (bits == 4) per = $realtime - last;
      last = $realtime;
      if (!tx) sh = {sh[6:0], sda};
      bits++;
      if (!tx && bits == 8 && n < 16) begin
         got[n] = sh;
         n++;
      end
   end
   always @(negedge scl) begin
      if (bits == 8) begin
         drive_low = !tx;
      end else if (bits == 9) begin
         bits = 0;
         tx = !tx && n > 0 && got[n-1] == 8'hA1;
         sh = RD_BYTE;
         drive_low = tx && !RD_BYTE[7];
      end else if (tx) begin
         drive_low = !sh[7 - bits];
      end
   end
endmodule

// ===== tb/smbus_port_control_bench.sv
// Self-checking bench for the SMBus port control block
`timescale 1ns/1ps
module smbus_port_control_bench;
   import smbus_ctl_pkg::*;
   // Short divider and no master filter keep each transfer near 5k cycles
   localparam logic [31:0] BASE = 32'h0020_0010;
   logic        ref_clk = 1'b0, reset_n = 1'b0, fast_mode_strap = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
   logic        reg_write = 1'b0, reg_read = 1'b0;
   logic        master_scl_oe, master_sda_oe, slave_sda_oe, e_low;
   logic        slave_scl_in = 1'b1, slave_sda_in = 1'b1;
   logic        slave_scl_filt, slave_sda_filt, slave_timeout;
   logic        init_checksum_fail = 1'b0, init_checksum_error;
   logic        slave_sda_drive_low = 1'b0;
   wire         master_scl_in = !master_scl_oe;
   wire         master_sda_in = !(master_sda_oe || e_low);
   int          fail_count = 0, check_count = 0;
   smbus_port_control #(.TIMEOUT_CYCLES(2000)) DUT (
      .ref_clk, .reset_n, .fast_mode_strap, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .master_scl_in,
      .master_scl_out(), .master_scl_oe, .master_sda_in,
      .master_sda_out(), .master_sda_oe, .slave_scl_in, .slave_sda_in,
      .slave_sda_out(), .slave_sda_oe, .slave_sda_drive_low,
      .slave_scl_filt, .slave_sda_filt, .slave_timeout,
      .init_checksum_fail, .init_checksum_error);
   eeprom_model EE (.scl(master_scl_in), .sda(master_sda_in),
                    .drive_low(e_low));
   always #2.5 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic do_reset(int k);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (k) @(posedge ref_clk);
      reset_n <= 1'b1;
   endtask
   // Starting an access also clears the done flag of the one before
   task automatic access(logic [31:0] w, output logic [31:0] d);
      wr(EEPROM_OFFSET, w | 32'h0200_0000);
      rd(EEPROM_OFFSET, d);
      chk("busy", {d[DONE_BIT], d[BUSY_BIT]}, 2'b01);
      for (int i = 0; i < 400 && d[DONE_BIT] !== 1'b1; i++) begin
         cyc(50);
         rd(EEPROM_OFFSET, d);
      end
      chk("done", {d[DONE_BIT], d[BUSY_BIT]}, 2'b10);
   endtask
   task automatic t_boot;
      rd(CTRL_OFFSET, v);
      chk("ctrl slow", v, {16'h0, DIV_SLOW});
      fast_mode_strap <= 1'b1;
      do_reset(2);
      rd(CTRL_OFFSET, v);
      chk("ctrl fast", v, {16'h0, DIV_FAST});
      fast_mode_strap <= 1'b0;
      wr(CTRL_OFFSET, 32'hFFFF_FFFF);
      rd(CTRL_OFFSET, v);
      chk("ctrl top", v, 32'h007F_FFFF);
      rd(12'h100, v);
      chk("unmapped", v, 32'h0);
      wr(CTRL_OFFSET, BASE);
   endtask
   task automatic t_write;
      int k0;
      k0 = EE.n;
      access(32'h005A_1234, v);
      chk("wr dev", EE.got[k0], 8'hA0);
      chk("wr ahi", EE.got[k0+1], 8'h12);
      chk("wr alo", EE.got[k0+2], 8'h34);
      chk("wr data", EE.got[k0+3], 8'h5A);
      chk("bit ns", EE.per > 501.0 && EE.per < 523.0, 1'b1);
   endtask
   task automatic t_read;
      int k0;
      k0 = EE.n;
      access(32'h0400_0042, v);
      chk("rd data", v[23:16], 8'hC3);
      chk("rd ahi", EE.got[k0+1], 8'h00);
      chk("rd alo", EE.got[k0+2], 8'h42);
      chk("rd dev", EE.got[k0+3], 8'hA1);
   endtask
   task automatic t_filter;
      int d;
      // Reserved code 3 must behave as the normal delay
      for (int c = 0; c < 4; c++) begin
         d = (c == 1) ? 20 : (c == 2) ? 1 : 200;
         wr(CTRL_OFFSET, BASE | (c << SFILT_LSB));
         @(posedge ref_clk);
         slave_sda_in <= 1'b0;
         slave_sda_drive_low <= 1'b1;
         cyc(d * 3 / 4);
         chk("filt hold", slave_sda_filt, 1'b1);
         chk("oe hold", slave_sda_oe, 1'b0);
         cyc(d / 4 + 6);
         chk("filt pass", slave_sda_filt, 1'b0);
         chk("oe pass", slave_sda_oe, 1'b1);
         slave_sda_in <= 1'b1;
         slave_sda_drive_low <= 1'b0;
         cyc(d + 6);
      end
   endtask
   task automatic t_timeout(logic dis);
      int hits;
      hits = 0;
      wr(CTRL_OFFSET, BASE | (32'(dis) << TDIS_BIT));
      slave_scl_in <= 1'b0;
      repeat (2400) begin
         @(posedge ref_clk);
         #1 if (slave_timeout === 1'b1) hits++;
      end
      slave_scl_in <= 1'b1;
      chk("slave timeout", hits, dis ? 0 : 1);
   endtask
   task automatic t_csum;
      for (int s = 0; s < 2; s++) begin
         wr(CTRL_OFFSET, BASE | (s << SKIP_BIT));
         wr(STATUS_OFFSET, 32'h10);
         @(posedge ref_clk);
         init_checksum_fail <= 1'b1;
         @(posedge ref_clk);
         init_checksum_fail <= 1'b0;
         cyc(2);
         chk("csum err", init_checksum_error, s == 0);
      end
   endtask
   // Left last: with the clock stopped the access never ends
   task automatic t_stop;
      int e0;
      wr(CTRL_OFFSET, (BASE & 32'hFFFF_0000) | 32'h1);
      e0 = EE.edges;
      wr(EEPROM_OFFSET, 32'h0000_0000);
      cyc(1000);
      chk("scl stopped", EE.edges - e0, 0);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #400us;
      fail_count++;
      close_out;
   end
   initial begin
      do_reset(20);
      t_boot;
      t_write;
      t_read;
      t_filter;
      t_timeout(1'b0);
      t_timeout(1'b1);
      t_csum;
      t_stop;
      close_out;
   end
endmodule
